// [logic/watchdog_unit.sv]
// Notes on behaviour
// - A restart clears counter and prescaler, so a full fresh period starts.
// - Overflow without restart raises NMI or system reset per selected action.
// - An overflow that raises an NMI sets the NMI status flag.
// - A counter restart clears the NMI status flag.
// - Control bit 9 selects action: 1 gives NMI, 0 gives reset.
// - Writing 1 to restart bit restarts; 0 ignored; bit always reads 0.
// - Run field 0xa stops, anything else runs; reads 0xa idle, 0x0 running.
// - Counting continues in HALT; overflow there fires the selected action.
// - In SLEEP counting follows the selected source; no source edges, no counting.
// - Clock control bit 8 keeps the counter clock in debug when 1.
// - Source field picks internal, low-speed, high-speed or external clock.
// - Divider gives 8192 to 65536 for fast sources, 128 low-speed, 1 external.
// - Protected control bits change only while the key holds 0x0096.
// - A 10-bit up counter overflow sets the NMI or reset period.
// - With the clock withheld in debug, state is held and resumes later.
module watchdog_unit #(
    parameter int unsigned DIV_BASE = wdt_pkg::DIV_BASE_DEFAULT
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [wdt_pkg::ADDR_W-1:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [15:0] rdata,
    input wire logic internal_oscillator,
    input wire logic low_speed_crystal,
    input wire logic high_speed_oscillator,
    input wire logic external_clock_input,
    input wire logic debug_mode,
    output logic nmi_req,
    output logic reset_req
);

    // ------------------------------------------------------------
    // Source clock synchronisers and edge detection
    // ------------------------------------------------------------
    // Three stages per pin: two to settle the level, one to find its rising edge
    logic [3:0] src_pins;
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] sync3_q;
    logic [3:0] src_rise;

    // Source clocks arrive as pins, so each is sampled as a plain level
    // Packed in source code order so the select field indexes them directly
    assign src_pins = {external_clock_input, high_speed_oscillator,
                       low_speed_crystal, internal_oscillator};

    // Edges are taken after the second stage only; the first may be metastable
    // A pin must stay high and low for one system clock each or an edge is lost
    // Edge latency is about three system clocks, well below any source period
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sync
            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    sync1_q[g] <= 1'b0;
                    sync2_q[g] <= 1'b0;
                    sync3_q[g] <= 1'b0;
                end else begin
                    sync1_q[g] <= src_pins[g];
                    sync2_q[g] <= sync1_q[g];
                    sync3_q[g] <= sync2_q[g];
                end
            end
            // Rising edge seen on the second stage only
            assign src_rise[g] = sync2_q[g] & ~sync3_q[g];
        end
    endgenerate

    // ------------------------------------------------------------
    // Divider decode
    // ------------------------------------------------------------
    // Terminal prescaler value for a source and divider code
    // DIV_BASE is a parameter so a short base can stand in for the slow real ratios
    function automatic logic [wdt_pkg::PRE_W-1:0] div_limit(
        input logic [1:0] src,
        input logic [1:0] div
    );
        int unsigned ratio;
        ratio = DIV_BASE << div;
        // Low-speed and external sources ignore the divider field
        case (src)
            wdt_pkg::SRC_LOW_SPEED: ratio = wdt_pkg::DIV_LOW_SPEED;
            wdt_pkg::SRC_EXTERNAL: ratio = wdt_pkg::DIV_EXTERNAL;
            default: ratio = DIV_BASE << div;
        endcase
        return wdt_pkg::PRE_W'(ratio - 1);
    endfunction

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    // Bus-visible registers
    logic [15:0] key_q;
    logic [15:0] key_d;
    wdt_pkg::clk_ctrl_s clk_ctrl_q;
    wdt_pkg::clk_ctrl_s clk_ctrl_d;
    wdt_pkg::ctrl_s ctrl_q;
    wdt_pkg::ctrl_s ctrl_d;

    // Counting state
    logic [wdt_pkg::PRE_W-1:0] pre_q;
    logic [wdt_pkg::PRE_W-1:0] pre_d;
    logic [wdt_pkg::CNT_W-1:0] cnt_q;
    logic [wdt_pkg::CNT_W-1:0] cnt_d;

    // Next values of the output flops
    logic [15:0] rdata_d;
    logic nmi_d;
    logic reset_d;

    // Decoded key state, strobes and counter clock enables
    logic unlocked;
    logic restart;
    logic clk_on;
    logic src_edge;
    logic pre_wrap;
    logic overflow;
    logic [wdt_pkg::PRE_W-1:0] pre_limit;

    // ------------------------------------------------------------
    // Counter clock gating
    // ------------------------------------------------------------
    // Selected source edge; a stopped source simply yields no edges
    assign src_edge = src_rise[clk_ctrl_q.src];

    // Counter clock reaches the counter only while running and not withheld
    // Withholding freezes prescaler and counter alike, so the period resumes intact
    assign clk_on = ctrl_q.running
                    && (clk_ctrl_q.dbg_run || !debug_mode);

    // Terminal count of the prescaler for the selected source and divider
    assign pre_limit = div_limit(clk_ctrl_q.src, clk_ctrl_q.div);

    // Compare with >= so a smaller divider chosen mid-count still wraps on the next source edge
    assign pre_wrap = clk_on && src_edge && (pre_q >= pre_limit);

    // Overflow on the 10-bit counter wrapping from all ones
    assign overflow = pre_wrap && (cnt_q == {wdt_pkg::CNT_W{1'b1}});

    // Only the exact key value opens the protected bits
    assign unlocked = (key_q == wdt_pkg::UNLOCK_KEY);

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Protected writes are silently dropped while the key is not loaded
    // The key itself is never protected, so software can always relock
    always_comb begin
        key_d = key_q;
        clk_ctrl_d = clk_ctrl_q;
        restart = 1'b0;
        ctrl_d = ctrl_q;
        if (wr_en) begin
            case (addr)
                wdt_pkg::KEY_OFS: begin
                    key_d = wdata;
                end
                wdt_pkg::CLK_CTRL_OFS: begin
                    if (unlocked) begin
                        clk_ctrl_d.dbg_run = wdata[wdt_pkg::DBG_RUN_BIT];
                        clk_ctrl_d.div = wdata[wdt_pkg::DIV_LSB +: 2];
                        clk_ctrl_d.src = wdata[wdt_pkg::SRC_LSB +: 2];
                    end
                end
                wdt_pkg::CTRL_OFS: begin
                    if (unlocked) begin
                        ctrl_d.act_nmi = wdata[wdt_pkg::ACTION_BIT];
                        // Only the stop code stops; any other value runs
                        ctrl_d.running = (wdata[wdt_pkg::RUN_LSB +: 4]
                                          != wdt_pkg::RUN_STOP_CODE);
                        // A restart in a locked write is dropped with the rest of the word
                        restart = wdata[wdt_pkg::RESTART_BIT];
                    end
                end
                default: begin
                    // Unmapped and read-only offsets take no write
                    key_d = key_q;
                end
            endcase
        end
        // Clear first so a same-cycle overflow still leaves the flag set
        // The flag records NMI overflows only; reset-mode overflows leave it alone
        if (restart) begin
            ctrl_d.nmi_flag = 1'b0;
        end
        if (overflow && ctrl_q.act_nmi) begin
            ctrl_d.nmi_flag = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Prescaler, counter and overflow action
    // ------------------------------------------------------------
    // Restart beats counting; an overflow in the same cycle still fires
    // Source edges seen while stopped or withheld are lost, not queued
    always_comb begin
        pre_d = pre_q;
        cnt_d = cnt_q;
        if (restart) begin
            pre_d = '0;
            cnt_d = '0;
        end else if (clk_on && src_edge) begin
            if (pre_wrap) begin
                pre_d = '0;
                cnt_d = cnt_q + 1'b1;
            end else begin
                pre_d = pre_q + 1'b1;
            end
        end
        // One-cycle pulses; the counter keeps wrapping after an overflow
        nmi_d = overflow && ctrl_q.act_nmi;
        reset_d = overflow && !ctrl_q.act_nmi;
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Read data stands for one cycle only, zero otherwise and when unmapped
    // Reserved bits always read as zero
    always_comb begin
        rdata_d = 16'h0000;
        if (rd_en) begin
            case (addr)
                wdt_pkg::KEY_OFS: begin
                    rdata_d = key_q;
                end
                wdt_pkg::CLK_CTRL_OFS: begin
                    rdata_d[wdt_pkg::DBG_RUN_BIT] = clk_ctrl_q.dbg_run;
                    rdata_d[wdt_pkg::DIV_LSB +: 2] = clk_ctrl_q.div;
                    rdata_d[wdt_pkg::SRC_LSB +: 2] = clk_ctrl_q.src;
                end
                wdt_pkg::CTRL_OFS: begin
                    rdata_d[wdt_pkg::ACTION_BIT] = ctrl_q.act_nmi;
                    rdata_d[wdt_pkg::NMI_FLAG_BIT] = ctrl_q.nmi_flag;
                    // Restart bit is left at zero on purpose
                    rdata_d[wdt_pkg::RUN_LSB +: 4] = ctrl_q.running
                        ? wdt_pkg::RUN_READ_RUNNING
                        : wdt_pkg::RUN_STOP_CODE;
                end
                wdt_pkg::COUNT_OFS: begin
                    // Lets software see how much of the period has gone
                    rdata_d[wdt_pkg::CNT_W-1:0] = cnt_q;
                end
                default: begin
                    rdata_d = 16'h0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registering
    // ------------------------------------------------------------
    // Key and control registers; reset leaves the unit locked and stopped
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            key_q <= wdt_pkg::KEY_RST;
            clk_ctrl_q <= wdt_pkg::CLK_CTRL_RST;
            ctrl_q <= wdt_pkg::CTRL_RST;
        end else begin
            key_q <= key_d;
            clk_ctrl_q <= clk_ctrl_d;
            ctrl_q <= ctrl_d;
        end
    end

    // Prescaler and counter; a reset starts a clean period from zero
    // Kept apart from the control flops so each group has its own pair of processes
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pre_q <= '0;
            cnt_q <= '0;
        end else begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
        end
    end

    // Bus answer and request pulses come straight from flops
    // so no decode glitch ever reaches an output pin
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata <= 16'h0000;
            nmi_req <= 1'b0;
            reset_req <= 1'b0;
        end else begin
            rdata <= rdata_d;
            nmi_req <= nmi_d;
            reset_req <= reset_d;
        end
    end

endmodule

// [include/wdt_pkg.sv]
package wdt_pkg;

    // ------------------------------------------------------------
    // Register map (word aligned byte addresses)
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] KEY_OFS = 8'h00;
    localparam logic [7:0] CLK_CTRL_OFS = 8'h04;
    localparam logic [7:0] CTRL_OFS = 8'h08;
    localparam logic [7:0] COUNT_OFS = 8'h0c;

    // ------------------------------------------------------------
    // Protection key
    // ------------------------------------------------------------
    localparam logic [15:0] UNLOCK_KEY = 16'h0096;
    localparam logic [15:0] KEY_RST = 16'h0000;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned DBG_RUN_BIT = 8;
    localparam int unsigned DIV_LSB = 4;
    localparam int unsigned SRC_LSB = 0;
    localparam int unsigned ACTION_BIT = 9;
    localparam int unsigned NMI_FLAG_BIT = 8;
    localparam int unsigned RESTART_BIT = 4;
    localparam int unsigned RUN_LSB = 0;

    // ------------------------------------------------------------
    // Codes and counts
    // ------------------------------------------------------------
    localparam logic [3:0] RUN_STOP_CODE = 4'ha;
    localparam logic [3:0] RUN_READ_RUNNING = 4'h0;
    localparam logic [1:0] SRC_INTERNAL = 2'h0;
    localparam logic [1:0] SRC_LOW_SPEED = 2'h1;
    localparam logic [1:0] SRC_HIGH_SPEED = 2'h2;
    localparam logic [1:0] SRC_EXTERNAL = 2'h3;
    localparam int unsigned CNT_W = 10;
    localparam int unsigned PRE_W = 16;
    localparam int unsigned DIV_BASE_DEFAULT = 8192;
    localparam int unsigned DIV_LOW_SPEED = 128;
    localparam int unsigned DIV_EXTERNAL = 1;

    // ------------------------------------------------------------
    // Register carriers and reset values
    // ------------------------------------------------------------
    typedef struct packed {
        logic dbg_run;
        logic [1:0] div;
        logic [1:0] src;
    } clk_ctrl_s;

    typedef struct packed {
        logic act_nmi;
        logic nmi_flag;
        logic running;
    } ctrl_s;

    localparam clk_ctrl_s CLK_CTRL_RST = '{dbg_run: 1'b0, div: 2'h0, src: 2'h0};
    localparam ctrl_s CTRL_RST = '{act_nmi: 1'b0, nmi_flag: 1'b0, running: 1'b0};

endpackage

// [bench/wdt_checker.sv]
// ----------------------------------------
// Port checker for the watchdog unit
// ----------------------------------------
module wdt_checker #(
    parameter int unsigned DIV_BASE = wdt_pkg::DIV_BASE_DEFAULT
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [wdt_pkg::ADDR_W-1:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [15:0] rdata,
    input wire logic nmi_req,
    input wire logic reset_req
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    logic [15:0] key_q;
    logic act_q;
    logic run_q;
    // Shadow of key, action and run state; the lock gate is what keeps it honest
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            key_q <= wdt_pkg::KEY_RST;
            act_q <= 1'b0;
            run_q <= 1'b0;
        end else if (wr_en && addr == wdt_pkg::KEY_OFS) begin
            key_q <= wdata;
        end else if (wr_en && addr == wdt_pkg::CTRL_OFS && key_q == wdt_pkg::UNLOCK_KEY) begin
            act_q <= wdata[9];
            run_q <= wdata[3:0] != wdt_pkg::RUN_STOP_CODE;
        end
    end
    sequence s_rd(logic [7:0] a);
        rd_en && addr == a;
    endsequence
    property p_key; s_rd(wdt_pkg::KEY_OFS) |=> rdata == key_q; endproperty
    property p_act; s_rd(wdt_pkg::CTRL_OFS) |=> rdata[9] == act_q && !rdata[4]; endproperty
    property p_run; s_rd(wdt_pkg::CTRL_OFS) |=> rdata[3:0] == (run_q ? 4'h0 : 4'ha); endproperty
    property p_clk; s_rd(wdt_pkg::CLK_CTRL_OFS) |=> (rdata & 16'hfecc) == 16'h0000; endproperty
    property p_cnt; s_rd(wdt_pkg::COUNT_OFS) |=> rdata[15:10] == 6'h00; endproperty
    property p_nmi1; nmi_req |=> !nmi_req; endproperty
    property p_rst1; reset_req |=> !reset_req; endproperty
    // A request follows its overflow by one edge, so the previous cycle's action rules
    property p_nmod; nmi_req |-> !reset_req && $past(act_q); endproperty
    property p_rmod; reset_req |-> !nmi_req && !$past(act_q); endproperty
    property p_stop; !run_q && !$past(run_q) && !$past(run_q, 2) |-> !nmi_req && !reset_req;
    endproperty
    a_key: assert property (p_key) else $error("key readback wrong");
    a_act: assert property (p_act) else $error("action or restart read wrong");
    a_run: assert property (p_run) else $error("run field read wrong");
    a_clk: assert property (p_clk) else $error("clock control reserved bits set");
    a_cnt: assert property (p_cnt) else $error("counter wider than ten bits");
    a_nmi1: assert property (p_nmi1) else $error("nmi pulse too long");
    a_rst1: assert property (p_rst1) else $error("reset pulse too long");
    a_nmod: assert property (p_nmod) else $error("nmi in reset mode");
    a_rmod: assert property (p_rmod) else $error("reset in nmi mode");
    a_stop: assert property (p_stop) else $error("request while stopped");
endmodule
bind watchdog_unit wdt_checker #(.DIV_BASE(DIV_BASE)) u_chk (.clk_sys(clk_sys), .srst(srst),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .nmi_req(nmi_req), .reset_req(reset_req));

// [bench/tb_top.sv]
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // Short prescaler keeps the fast-source runs brief
    localparam int unsigned DIVB = 4;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [15:0] rdata;
    logic [3:0] pins = 4'h0;
    logic debug_mode = 1'b0;
    logic nmi_req;
    logic reset_req;
    int error_cnt = 0;
    int samples_checked = 0;
    int nmi_seen = 0;
    int rst_seen = 0;
    int cnt = 0, pre = 0, flag = 0, act = 0, run = 0, src = 0, dv = 0, dbg = 0;
    int exp_nmi = 0, exp_rst = 0;
    always #50 clk_sys = ~clk_sys;
    // Count request pulses as they appear
    always @(posedge clk_sys) begin
        if (nmi_req === 1'b1) nmi_seen++;
        if (reset_req === 1'b1) rst_seen++;
    end
    watchdog_unit #(.DIV_BASE(DIVB)) u_dut (.clk_sys(clk_sys), .srst(srst), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .internal_oscillator(pins[0]), .low_speed_crystal(pins[1]),
        .high_speed_oscillator(pins[2]), .external_clock_input(pins[3]),
        .debug_mode(debug_mode), .nmi_req(nmi_req), .reset_req(reset_req));
    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic ctl(input logic [15:0] d);
        wr(wdt_pkg::CTRL_OFS, d);
        act = d[9];
        run = d[3:0] != 4'ha;
        if (d[4]) begin
            cnt = 0;
            pre = 0;
            flag = 0;
        end
    endtask
    task automatic cfg(input logic [15:0] d);
        wr(wdt_pkg::CLK_CTRL_OFS, d);
        dbg = d[8];
        dv = d[5:4];
        src = d[1:0];
    endtask
    function automatic logic [15:0] ctrl_exp();
        return 16'((act << 9) | (flag << 8) | (run ? 0 : 10));
    endfunction
    // Source edges with the model stepping after each; pins idle low between bursts
    task automatic edges(input int n);
        int ratio;
        ratio = (src == 1) ? 128 : (src == 3) ? 1 : (DIVB << dv);
        repeat (n) begin
            @(posedge clk_sys) pins[src] <= 1'b1;
            repeat (3) @(posedge clk_sys);
            pins[src] <= 1'b0;
            repeat (3) @(posedge clk_sys);
            if (run && !(debug_mode && !dbg)) begin
                pre++;
                if (pre >= ratio) begin
                    pre = 0;
                    cnt++;
                end
                if (cnt == 1024) begin
                    cnt = 0;
                    if (act) flag = 1;
                    if (act) exp_nmi++;
                    else exp_rst++;
                end
            end
        end
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #10000000;
        error_cnt++;
        $display("CHECK FAILED at %0t: run too long", $time);
        final_report();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(41581));
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        rchk(wdt_pkg::CTRL_OFS, 16'h000a);
        rchk(8'h10, 16'h0000);
        wr(wdt_pkg::CTRL_OFS, 16'h0210);
        rchk(wdt_pkg::CTRL_OFS, 16'h000a);
        wr(wdt_pkg::KEY_OFS, wdt_pkg::UNLOCK_KEY);
        rchk(wdt_pkg::KEY_OFS, wdt_pkg::UNLOCK_KEY);
        cfg(16'h0003);
        ctl(16'h0210);
        rchk(wdt_pkg::CTRL_OFS, ctrl_exp());
        edges($urandom_range(20, 1));
        rchk(wdt_pkg::COUNT_OFS, 16'(cnt));
        ctl(16'h020a);
        edges(5);
        rchk(wdt_pkg::COUNT_OFS, 16'(cnt));
        ctl(16'h0215);
        rchk(wdt_pkg::COUNT_OFS, 16'h0000);
        edges(1024);
        chk(16'(nmi_seen), 16'(exp_nmi));
        rchk(wdt_pkg::CTRL_OFS, ctrl_exp());
        ctl(16'h0210);
        rchk(wdt_pkg::CTRL_OFS, ctrl_exp());
        ctl(16'h0010);
        edges(1024);
        chk(16'(rst_seen), 16'(exp_rst));
        debug_mode <= 1'b1;
        edges(3);
        rchk(wdt_pkg::COUNT_OFS, 16'(cnt));
        cfg(16'h0103);
        edges(3);
        rchk(wdt_pkg::COUNT_OFS, 16'(cnt));
        @(posedge clk_sys) debug_mode <= 1'b0;
        for (int s = 0; s < 3; s++) begin
            cfg(16'(($urandom_range(3, 0) << 4) | s));
            ctl(16'h0010);
            edges($urandom_range(140, 20));
            rchk(wdt_pkg::COUNT_OFS, 16'(cnt));
        end
        wr(wdt_pkg::KEY_OFS, 16'h0000);
        rchk(wdt_pkg::KEY_OFS, 16'h0000);
        wr(wdt_pkg::CLK_CTRL_OFS, 16'h0000);
        rchk(wdt_pkg::CLK_CTRL_OFS, 16'((dbg << 8) | (dv << 4) | src));
        final_report();
    end
endmodule
